// [shared/lsdc_defs.vh]
// register offsets, field positions and reset values of the low-side
// driver control block; assumes 8-bit die-to-die register bus, byte offsets
`ifndef LSDC_DEFS_VH
`define LSDC_DEFS_VH
`define LSDC_ADDR_W 8
`define LSDC_OFS_CTRL 8'h30
`define LSDC_OFS_STAT 8'h31
`define LSDC_OFS_UNLK 8'h32
`define LSDC_CTRL_RST 8'h00
`define LSDC_UNLK_RST 4'h0
`define LSDC_UNLOCK_KEY 4'h5
`define LSDC_CTRL_WMASK 8'hBF
`define LSDC_B_OTIE 7
`define LSDC_B_CS2 5
`define LSDC_B_CS1 4
`define LSDC_B_PWM2 3
`define LSDC_B_PWM1 2
`define LSDC_B_ON2 1
`define LSDC_B_ON1 0
`define LSDC_B_OTP 7
`define LSDC_B_CL2 3
`define LSDC_B_CL1 2
`define LSDC_B_OL2 1
`define LSDC_B_OL1 0
`endif

// [core/lsdc_sync.v]
// two-flop synchroniser bank for the analog status inputs
// assumes inputs are asynchronous levels from the analog section
`timescale 1ns/10ps
module lsdc_sync
#(
  parameter W = 6
)
(
  input wire sys_clk,
  input wire nrst,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  // first stage is read only by the second stage
  reg [W-1:0] meta_r;
  reg [W-1:0] stab_r;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      // one bit, two flops
      always @(posedge sys_clk)
      begin
        if (!nrst)
        begin
          meta_r[i] <= 1'b0;
          stab_r[i] <= 1'b0;
        end
        else
        begin
          meta_r[i] <= async_in[i];
          stab_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign sync_out = stab_r;
endmodule

// [core/lsdc_top.v]
// low-side driver control: control, status and unlock registers
// assumes the die-to-die bus presents addr, wdata, wr and rd strobes
// on sys_clk (40 MHz); analog status arrives asynchronously
//
// Notes on behaviour
// - bit 7 gates overtemperature interrupt request
// - bits 5,4 pick pwm channel per driver
// - bits 3,2 enable pwm modulation per driver
// - bits 1,0 switch drivers, only when unlocked
// - status 7 shows overtemp, drivers forced off
// - status read clears pending overtemp flag
// - status 3,2 show current limitation
// - status 1,0 show open load
// - drivers held off outside normal mode
// - only key 0x5 unlocks driver control
// - no open load reported while driver off
// - control write after overtemp re-enables drivers
// - regulator overvoltage clears both enable bits
`timescale 1ns/10ps
`include "lsdc_defs.vh"
module lsdc_top
(
  input wire sys_clk,
  input wire nrst,
  input wire [7:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [7:0] bus_rdata,
  input wire normal_mode,
  input wire regulator_overvoltage,
  input wire overtemp_present,
  input wire drv1_current_limit,
  input wire drv2_current_limit,
  input wire drv1_open_load,
  input wire drv2_open_load,
  input wire pwm_ch0,
  input wire pwm_ch1,
  output reg drv1_gate,
  output reg drv2_gate,
  output wire overtemp_irq_req,
  output wire overtemp_irq_flag
);
  // decode used for read and write paths
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // synchronised analog status
  wire [5:0] st_s;
  wire ot_s;
  wire cl1_s;
  wire cl2_s;
  wire ol1_s;
  wire ol2_s;
  wire ovv_s;
  wire nm_s;

  // analog levels cross into sys_clk through two flops
  lsdc_sync #(.W(6)) u_sync
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in({regulator_overvoltage, overtemp_present, drv2_current_limit,
      drv1_current_limit, drv2_open_load, drv1_open_load}),
    .sync_out(st_s)
  );
  assign {ovv_s, ot_s, cl2_s, cl1_s, ol2_s, ol1_s} = st_s;

  // mode and pwm inputs come from digital logic on sys_clk
  assign nm_s = normal_mode;

  // register state
  reg [7:0] driver_control_reg_r;
  reg [3:0] driver_unlock_reg_r;
  reg unlocked_r; // last unlock write was the key, no overvoltage since
  reg irq_flag_r; // pending overtemperature interrupt
  reg ot_d_r; // previous overtemp, for rising edge
  reg latch_off_r; // shutdown held until a control write once overtemp is gone
  reg ovv_d_r;

  wire wr_ctrl = bus_wr && hit(bus_addr, `LSDC_OFS_CTRL);
  wire wr_unlk = bus_wr && hit(bus_addr, `LSDC_OFS_UNLK);
  wire rd_stat = bus_rd && hit(bus_addr, `LSDC_OFS_STAT);
  wire ot_rise = ot_s && !ot_d_r;
  wire ovv_rise = ovv_s && !ovv_d_r;

  // control register; overvoltage clears enables after the write
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      driver_control_reg_r <= `LSDC_CTRL_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        // bit 6 stays zero
        driver_control_reg_r <= bus_wdata & `LSDC_CTRL_WMASK;
      end
      if (ovv_s)
      begin
        driver_control_reg_r[`LSDC_B_ON2] <= 1'b0;
        driver_control_reg_r[`LSDC_B_ON1] <= 1'b0;
      end
    end
  end

  // unlock register and lock state; overvoltage relocks
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      driver_unlock_reg_r <= `LSDC_UNLK_RST;
      unlocked_r <= 1'b0;
    end
    else
    begin
      if (wr_unlk)
      begin
        driver_unlock_reg_r <= bus_wdata[3:0];
      end
      if (wr_unlk)
      begin
        // only the key opens control, anything else shuts it
        unlocked_r <= (bus_wdata[3:0] == `LSDC_UNLOCK_KEY);
      end
      else if (ovv_rise)
      begin
        unlocked_r <= 1'b0;
      end
    end
  end

  // overtemp shutdown latch and interrupt flag
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      irq_flag_r <= 1'b0;
      ot_d_r <= 1'b0;
      ovv_d_r <= 1'b0;
      latch_off_r <= 1'b0;
    end
    else
    begin
      ot_d_r <= ot_s;
      ovv_d_r <= ovv_s;
      // set wins over the read clear
      if (ot_rise)
        irq_flag_r <= 1'b1;
      else if (rd_stat)
        irq_flag_r <= 1'b0;
      // a control write once the condition is gone re-arms drivers
      if (ot_s)
        latch_off_r <= 1'b1;
      else if (wr_ctrl)
        latch_off_r <= 1'b0;
    end
  end

  assign overtemp_irq_flag = irq_flag_r;
  // enable bit gates the request only, flag still latches
  assign overtemp_irq_req = irq_flag_r &&
    driver_control_reg_r[`LSDC_B_OTIE];

  // per-driver gate computation
  reg pwm1_sel;
  reg pwm2_sel;
  reg on1_nxt;
  reg on2_nxt;
  reg allow;
  always @*
  begin
    pwm1_sel = driver_control_reg_r[`LSDC_B_CS1] ? pwm_ch1 : pwm_ch0;
    pwm2_sel = driver_control_reg_r[`LSDC_B_CS2] ? pwm_ch1 : pwm_ch0;
    // unlock, normal mode and no shutdown all needed
    allow = unlocked_r && nm_s && !latch_off_r && !ot_s;
    on1_nxt = allow && driver_control_reg_r[`LSDC_B_ON1] &&
      (!driver_control_reg_r[`LSDC_B_PWM1] || pwm1_sel);
    on2_nxt = allow && driver_control_reg_r[`LSDC_B_ON2] &&
      (!driver_control_reg_r[`LSDC_B_PWM2] || pwm2_sel);
  end

  // registered driver gates
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      drv1_gate <= 1'b0;
      drv2_gate <= 1'b0;
    end
    else
    begin
      drv1_gate <= on1_nxt;
      drv2_gate <= on2_nxt;
    end
  end

  // status word; open load masked while the gate is off
  wire [7:0] stat_w = {ot_s, 3'b000, cl2_s, cl1_s,
    ol2_s && drv2_gate, ol1_s && drv1_gate};

  // registered read data, one cycle after rd
  always @(posedge sys_clk)
  begin
    if (!nrst)
      bus_rdata <= 8'h00;
    else if (bus_rd)
    begin
      if (hit(bus_addr, `LSDC_OFS_CTRL))
        bus_rdata <= driver_control_reg_r;
      else if (hit(bus_addr, `LSDC_OFS_STAT))
        bus_rdata <= stat_w;
      else if (hit(bus_addr, `LSDC_OFS_UNLK))
        bus_rdata <= {4'h0, driver_unlock_reg_r};
      else
        bus_rdata <= 8'h00; // unmapped reads zero
    end
  end
endmodule

// [tb/lsdc_chk_sva.sv]
// port assertions for lsdc_top
// bound to every lsdc_top; bus strobes are one cycle wide
`timescale 1ns/10ps
module lsdc_chk
(
  input wire sys_clk,
  input wire nrst,
  input wire [7:0] bus_addr,
  input wire bus_rd,
  input wire [7:0] bus_rdata,
  input wire normal_mode,
  input wire regulator_overvoltage,
  input wire overtemp_present,
  input wire drv1_gate,
  input wire drv2_gate,
  input wire overtemp_irq_req,
  input wire overtemp_irq_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // both drivers idle; status read strobe
  wire off = !drv1_gate && !drv2_gate;
  wire rs = bus_rd && bus_addr == 8'h31;
  property p_req; overtemp_irq_req |-> overtemp_irq_flag; endproperty
  a_req: assert property (p_req) else $error("req");
  property p_ot; overtemp_present [*6] |-> off; endproperty
  a_ot: assert property (p_ot) else $error("ot");
  property p_clr; !overtemp_present [*4] ##0 rs |=> !overtemp_irq_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_md; !normal_mode [*2] |-> off; endproperty
  a_md: assert property (p_md) else $error("mode");
  property p_ol; !drv1_gate [*4] ##0 rs |=> !bus_rdata[0]; endproperty
  a_ol: assert property (p_ol) else $error("ol");
  property p_ov; regulator_overvoltage [*6] |-> off; endproperty
  a_ov: assert property (p_ov) else $error("ov");
  property p_b6; bus_rd |=> !bus_rdata[6]; endproperty
  a_b6: assert property (p_b6) else $error("b6");
  // reset clears outputs even while reset is low
  property p_rst; disable iff (1'b0)
    !nrst |=> off && !overtemp_irq_flag && bus_rdata == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  c_on: cover property ($rose(drv1_gate));
  c_irq: cover property (overtemp_irq_req);
  c_rs: cover property (rs);
endmodule
bind lsdc_top lsdc_chk u_chk
(
  .sys_clk(sys_clk),
  .nrst(nrst),
  .bus_addr(bus_addr),
  .bus_rd(bus_rd),
  .bus_rdata(bus_rdata),
  .normal_mode(normal_mode),
  .regulator_overvoltage(regulator_overvoltage),
  .overtemp_present(overtemp_present),
  .drv1_gate(drv1_gate),
  .drv2_gate(drv2_gate),
  .overtemp_irq_req(overtemp_irq_req),
  .overtemp_irq_flag(overtemp_irq_flag)
);

// [tb/lsdc_host.sv]
// die-to-die bus host model for lsdc_top
// strobes change just after sys_clk rises, one access at a time
`timescale 1ns/10ps
module lsdc_host
(
  input wire sys_clk,
  input wire [7:0] bus_rdata,
  output reg [7:0] bus_addr = 8'h00,
  output reg [7:0] bus_wdata = 8'h00,
  output reg bus_wr = 1'b0,
  output reg bus_rd = 1'b0
);
  // one-cycle write; data inverted once released
  task wr(input [7:0] a, input [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    bus_wdata <= ~d;
  endtask
  // data taken after the answering edge lands
  task rd(input [7:0] a, output [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
endmodule

// [tb/lsdc_top_tb.sv]
// self-checking bench for lsdc_top
// assumes lsdc_host owns the bus; analog levels driven here
`timescale 1ns/10ps
module lsdc_top_tb;
  reg sys_clk = 1'b0;
  reg nrst = 1'b0;
  reg nm = 1'b1, ov = 1'b0, ot = 1'b0; // mode, overvoltage, overtemp
  reg [1:0] cl = 2'h0, ol = 2'h0, pw = 2'h0; // per driver / channel
  reg [7:0] v;
  wire [7:0] bus_addr, bus_wdata, bus_rdata;
  wire bus_wr, bus_rd, g1, g2, req, flg;
  integer miscompares = 0;
  integer n_tests = 0;
  lsdc_host h (.sys_clk(sys_clk), .bus_rdata(bus_rdata),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd));
  lsdc_top dut (.sys_clk(sys_clk), .nrst(nrst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .normal_mode(nm), .regulator_overvoltage(ov),
    .overtemp_present(ot), .drv1_current_limit(cl[0]),
    .drv2_current_limit(cl[1]), .drv1_open_load(ol[0]),
    .drv2_open_load(ol[1]), .pwm_ch0(pw[0]), .pwm_ch1(pw[1]),
    .drv1_gate(g1), .drv2_gate(g2), .overtemp_irq_req(req),
    .overtemp_irq_flag(flg));
  initial
    forever #12.5 sys_clk = ~sys_clk;
  task chk(input [7:0] s, input [7:0] e);
    n_tests = n_tests + 1;
    if (s !== e)
    begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: %h, expected %h", $time, s, e);
    end
  endtask
  // masked register read
  task rc(input [7:0] ad, input [7:0] m, input [7:0] e);
    h.rd(ad, v);
    chk(v & m, e);
  endtask
  // gates after n edges; synced overtemp needs n of at least 3, overvoltage 4
  task gc(input integer n, input [7:0] e);
    repeat (n) @(posedge sys_clk);
    #1 chk({6'h0, g2, g1}, e);
  endtask
  task complete_run;
    $display("%0d mismatches in %0d checks", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard, far above the roughly 140 cycles needed
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    miscompares = miscompares + 1;
    complete_run;
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    rc(8'h30, 8'hFF, 8'h00);
    rc(8'h31, 8'hFF, 8'h00);
    h.wr(8'h30, 8'hFF);
    gc(3, 8'h00);
    rc(8'h30, 8'hFC, 8'hBC);
    h.wr(8'h32, 8'h03);
    h.wr(8'h30, 8'h03);
    gc(3, 8'h00);
    @(posedge sys_clk) pw <= 2'h1;
    h.wr(8'h32, 8'h05);
    h.wr(8'h30, 8'h17);
    gc(3, 8'h02);
    @(posedge sys_clk) {pw, cl, ol} <= 6'h2F;
    gc(4, 8'h03);
    rc(8'h31, 8'hFF, 8'h0F);
    @(posedge sys_clk) pw <= 2'h1;
    gc(3, 8'h02);
    rc(8'h31, 8'hFF, 8'h0E);
    @(posedge sys_clk) {cl, ol, ot} <= 5'h01;
    gc(5, 8'h00);
    chk({6'h0, req, flg}, 8'h01);
    rc(8'h31, 8'hFF, 8'h80);
    @(posedge sys_clk) ot <= 1'b0;
    gc(4, 8'h00);
    rc(8'h31, 8'hFF, 8'h00);
    chk({7'h0, flg}, 8'h00);
    h.wr(8'h30, 8'h97);
    gc(3, 8'h02);
    @(posedge sys_clk) ot <= 1'b1;
    gc(5, 8'h00);
    chk({6'h0, req, flg}, 8'h03);
    @(posedge sys_clk) ot <= 1'b0;
    gc(4, 8'h00);
    h.wr(8'h30, 8'h03);
    gc(3, 8'h03);
    @(posedge sys_clk) nm <= 1'b0;
    gc(3, 8'h00);
    @(posedge sys_clk) nm <= 1'b1;
    gc(3, 8'h03);
    @(posedge sys_clk) ov <= 1'b1;
    gc(5, 8'h00);
    rc(8'h30, 8'h03, 8'h00);
    @(posedge sys_clk) ov <= 1'b0;
    // let the synced overvoltage fall so the write is not eaten by it
    gc(3, 8'h00);
    h.wr(8'h30, 8'h03);
    gc(3, 8'h00);
    rc(8'h30, 8'hFF, 8'h03);
    h.wr(8'h32, 8'h05);
    rc(8'h32, 8'hFF, 8'h05);
    h.wr(8'h30, 8'h03);
    gc(3, 8'h03);
    // driver 2 modulated from channel 1, driver 1 steady on
    h.wr(8'h30, 8'h2B);
    gc(3, 8'h01);
    @(posedge sys_clk) pw <= 2'h2;
    gc(3, 8'h03);
    complete_run;
  end
endmodule
